// ==== logic/atc_ctl.sv ====
/*
 * Asynchronous-transmit FIFO control with its link enhancement control
 * register. Packets enter from the host DMA side as 32-bit words with an
 * end-of-packet mark and leave towards the physical layer, either early
 * at a threshold or store-and-forward.
 * Assumes: one clock; a plain register port with read data one cycle
 * later; packets no longer than the FIFO; the writer keeps supplying
 * the packet after an underrun so it can be sent again whole.
 */
// Behaviour
// - The enhancement bits only act while the master gate input is 1.
// - Bits 31 to 16 of the enhancement register read as zero.
// - The reorder-disable bit, reset 0, turns off out-of-order pipelining.
// - The two-bit start level picks 2K, 1.7K, 1K or 512 byte thresholds.
// - After an underrun the retry of that packet uses the 2K threshold.
// - Below 2K, sending starts at the threshold or at a whole packet.
// - An underrun aborts the packet; it is resent only once whole.
// - At 2K, a packet is held until its end-of-packet mark arrives.
// - A zero retry count forces store-and-forward.
// - The sticky bits reload their reset value (level 1.7K) only on the global reset pin.
module atc_ctl #(
   parameter int AW = 9
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic        GLOBAL_RESET_PIN_N,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic        LINK_FEATURE_MASTER_GATE,
   input  wire logic        RETRIES_ZERO,
   input  wire logic        IN_VALID,
   output logic             IN_READY,
   input  wire logic [31:0] IN_DATA,
   input  wire logic        IN_LAST,
   output logic             OUT_VALID,
   input  wire logic        OUT_READY,
   output logic      [31:0] OUT_DATA,
   output logic             OUT_LAST,
   output logic             OUT_ABORT,
   output logic             PIPELINE_EN
);
   localparam int         DW    = 33;
   localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);

   typedef struct packed {
      logic                global_reset_pin_meta;
      logic                global_reset_pin_sync;
      logic                reorder_dis;
      atc_pkg::atc_level_e level;
      logic [AW:0]         wr_ptr;
      logic [AW:0]         rd_ptr;
      logic [AW:0]         pkt_ptr;
      logic [AW:0]         eop_cnt;
      logic                sf_retry;
      atc_pkg::atc_fsm_e   fsm;
      logic                abort;
      logic [31:0]         rdata;
   } atc_state_s;

   atc_state_s  st;
   atc_state_s  next_st;

   logic        wr_fire;
   logic        rd_fire;
   logic        last_out;
   logic [AW:0] occ_words;
   logic        pkt_ready;
   logic        start_ok;
   logic        store_fwd;
   logic        fifo_has_data;

   atc_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

   atc_ram #(
      .AW (AW),
      .DW (DW)
   ) atc_ram_i (
      .CLK_SYS (CLK_SYS),
      .port_m  (mem_bus)
   );

   atc_thresh #(
      .AW (AW)
   ) atc_thresh_i (
      .level        (st.level),
      .gate         (LINK_FEATURE_MASTER_GATE),
      .retries_zero (RETRIES_ZERO),
      .sf_retry     (st.sf_retry),
      .occ_words    (occ_words),
      .pkt_ready    (pkt_ready),
      .start_ok     (start_ok),
      .store_fwd    (store_fwd)
   );

   // Space of the packet being sent stays held until it completes
   assign occ_words     = st.wr_ptr - st.pkt_ptr;
   assign pkt_ready     = (st.eop_cnt != '0);
   assign fifo_has_data = (st.rd_ptr != st.wr_ptr);
   assign IN_READY      = (occ_words != DEPTH);
   assign wr_fire       = IN_VALID && IN_READY;
   assign OUT_VALID     = (st.fsm == atc_pkg::ATC_SHOW);
   assign OUT_DATA      = mem_bus.rdata[31:0];
   assign OUT_LAST      = mem_bus.rdata[32];
   assign rd_fire       = OUT_VALID && OUT_READY;
   assign last_out      = rd_fire && OUT_LAST;
   assign OUT_ABORT     = st.abort;
   assign REG_RDATA     = st.rdata;
   assign PIPELINE_EN   =
      !(LINK_FEATURE_MASTER_GATE && st.reorder_dis);

   assign mem_bus.we    = wr_fire;
   assign mem_bus.waddr = st.wr_ptr[AW-1:0];
   assign mem_bus.wdata = {IN_LAST, IN_DATA};
   assign mem_bus.re    = (st.fsm == atc_pkg::ATC_FETCH) && fifo_has_data;
   assign mem_bus.raddr = st.rd_ptr[AW-1:0];

   always_comb begin
      next_st = st;
      next_st.global_reset_pin_meta = GLOBAL_RESET_PIN_N;
      next_st.global_reset_pin_sync = st.global_reset_pin_meta;
      next_st.abort = 1'b0;
      next_st.rdata = '0;

      // Register writes
      if (REG_WR && REG_ADDR == atc_pkg::LEC_OFFSET) begin
         next_st.reorder_dis = REG_WDATA[atc_pkg::REORDER_BIT];
         next_st.level = atc_pkg::atc_level_e'(
            REG_WDATA[atc_pkg::LEVEL_MSB:atc_pkg::LEVEL_LSB]);
      end

      // Register reads, answered in the next cycle
      if (REG_RD) begin
         case (REG_ADDR)
            atc_pkg::LEC_OFFSET: begin
               next_st.rdata[atc_pkg::REORDER_BIT] = st.reorder_dis;
               next_st.rdata[atc_pkg::RSVD14_BIT]  = 1'b0;
               next_st.rdata[atc_pkg::LEVEL_MSB:atc_pkg::LEVEL_LSB] =
                  st.level;
               next_st.rdata[31:16] = 16'h0000;
            end
            atc_pkg::STAT_OFFSET: begin
               next_st.rdata[atc_pkg::STAT_OCC_LSB +: AW+1] = occ_words;
               next_st.rdata[atc_pkg::STAT_RETRY_BIT] = st.sf_retry;
               next_st.rdata[atc_pkg::STAT_SEND_BIT] =
                  (st.fsm != atc_pkg::ATC_IDLE);
               next_st.rdata[atc_pkg::STAT_SF_BIT] = store_fwd;
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end

      // Filling side
      if (wr_fire) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      next_st.eop_cnt = st.eop_cnt
                      + (AW+1)'(wr_fire && IN_LAST)
                      - (AW+1)'(last_out);

      // Draining side
      case (st.fsm)
         atc_pkg::ATC_IDLE: begin
            if (start_ok) begin
               next_st.fsm = atc_pkg::ATC_FETCH;
            end
         end
         atc_pkg::ATC_FETCH: begin
            if (fifo_has_data) begin
               next_st.fsm = atc_pkg::ATC_SHOW;
            end else begin
               // Underrun: abort, rewind, resend only when whole
               next_st.abort    = 1'b1;
               next_st.rd_ptr   = st.pkt_ptr;
               next_st.sf_retry = 1'b1;
               next_st.fsm      = atc_pkg::ATC_IDLE;
            end
         end
         atc_pkg::ATC_SHOW: begin
            if (rd_fire) begin
               next_st.rd_ptr = st.rd_ptr + 1'b1;
               if (OUT_LAST) begin
                  next_st.pkt_ptr  = st.rd_ptr + 1'b1;
                  next_st.sf_retry = 1'b0;
                  next_st.fsm      = atc_pkg::ATC_IDLE;
               end else begin
                  next_st.fsm = atc_pkg::ATC_FETCH;
               end
            end
         end
         default: begin
            next_st.fsm = atc_pkg::ATC_IDLE;
         end
      endcase

      // Either reset clears the working state
      if (!RESET_N || !st.global_reset_pin_sync) begin
         next_st.wr_ptr   = '0;
         next_st.rd_ptr   = '0;
         next_st.pkt_ptr  = '0;
         next_st.eop_cnt  = '0;
         next_st.sf_retry = 1'b0;
         next_st.fsm      = atc_pkg::ATC_IDLE;
         next_st.abort    = 1'b0;
         next_st.rdata    = '0;
      end
      // Sticky bits follow the global reset pin only
      if (!st.global_reset_pin_sync) begin
         next_st.reorder_dis =
            atc_pkg::LEC_RESET[atc_pkg::REORDER_BIT];
         next_st.level = atc_pkg::atc_level_e'(
            atc_pkg::LEC_RESET[atc_pkg::LEVEL_MSB:atc_pkg::LEVEL_LSB]);
      end
      if (!RESET_N) begin
         next_st.global_reset_pin_meta = 1'b1;
         next_st.global_reset_pin_sync = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      st <= next_st;
   end
endmodule

// ==== logic/atc_pkg.sv ====
/*
 * Shared constants for the asynchronous-transmit threshold control block:
 * register offsets, field positions, reset values, threshold sizes, states.
 * Assumes byte offsets on an 8-bit register address.
 */
package atc_pkg;

   localparam logic [7:0]  LEC_OFFSET     = 8'hF4;
   localparam logic [7:0]  STAT_OFFSET    = 8'hF0;
   localparam logic [31:0] LEC_RESET      = 32'h0000_1000;

   localparam int          REORDER_BIT    = 15;
   localparam int          RSVD14_BIT     = 14;
   localparam int          LEVEL_LSB      = 12;
   localparam int          LEVEL_MSB      = 13;

   localparam int          STAT_OCC_LSB   = 0;
   localparam int          STAT_RETRY_BIT = 16;
   localparam int          STAT_SEND_BIT  = 17;
   localparam int          STAT_SF_BIT    = 18;

   localparam int          BYTES_PER_WORD = 4;
   localparam int          TH_SF_BYTES    = 2048;
   localparam int          TH_L1_BYTES    = 1740;
   localparam int          TH_L2_BYTES    = 1024;
   localparam int          TH_L3_BYTES    = 512;
   localparam int          TH_L1_WORDS    =
      (TH_L1_BYTES + BYTES_PER_WORD - 1) / BYTES_PER_WORD;
   localparam int          TH_L2_WORDS    =
      (TH_L2_BYTES + BYTES_PER_WORD - 1) / BYTES_PER_WORD;
   localparam int          TH_L3_WORDS    =
      (TH_L3_BYTES + BYTES_PER_WORD - 1) / BYTES_PER_WORD;
   localparam int          TH_SF_WORDS    = TH_SF_BYTES / BYTES_PER_WORD;

   typedef enum logic [1:0] {
      ATC_LVL_SF  = 2'b00,
      ATC_LVL_1K7 = 2'b01,
      ATC_LVL_1K  = 2'b10,
      ATC_LVL_512 = 2'b11
   } atc_level_e;

   typedef enum logic [2:0] {
      ATC_IDLE  = 3'b001,
      ATC_FETCH = 3'b010,
      ATC_SHOW  = 3'b100
   } atc_fsm_e;

endpackage

// ==== logic/atc_mem_if.sv ====
/*
 * Carrier between the transmit control and its packet memory.
 * Assumes both ends sit on the same clock.
 */
interface atc_mem_if #(
   parameter int AW = 9,
   parameter int DW = 33
);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic          re;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;

   modport ctl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// ==== logic/atc_ram.sv ====
/*
 * Simple dual-port packet memory, read data from a register.
 * Assumes one clock; contents are undefined after reset.
 */
module atc_ram #(
   parameter int AW = 9,
   parameter int DW = 33
) (
   input wire logic CLK_SYS,
   atc_mem_if.mem   port_m
);
   logic [DW-1:0] store [2**AW];
   logic [DW-1:0] q;

   always_ff @(posedge CLK_SYS) begin
      if (port_m.we) begin
         store[port_m.waddr] <= port_m.wdata;
      end
      if (port_m.re) begin
         q <= store[port_m.raddr];
      end
   end

   assign port_m.rdata = q;
endmodule

// ==== logic/atc_thresh.sv ====
/*
 * Start decision for the head packet: picks the threshold and the
 * store-and-forward cases. Purely combinational, same clock as the caller.
 */
module atc_thresh #(
   parameter int AW = 9
) (
   input  wire atc_pkg::atc_level_e level,
   input  wire logic                gate,
   input  wire logic                retries_zero,
   input  wire logic                sf_retry,
   input  wire logic [AW:0]         occ_words,
   input  wire logic                pkt_ready,
   output logic                     start_ok,
   output logic                     store_fwd
);
   atc_pkg::atc_level_e eff;
   logic [AW:0]         thr;

   always_comb begin
      eff = gate ? level : atc_pkg::ATC_LVL_SF;
      store_fwd = (eff == atc_pkg::ATC_LVL_SF)
                | retries_zero
                | sf_retry;
      case (eff)
         atc_pkg::ATC_LVL_1K7: thr = (AW+1)'(atc_pkg::TH_L1_WORDS);
         atc_pkg::ATC_LVL_1K:  thr = (AW+1)'(atc_pkg::TH_L2_WORDS);
         atc_pkg::ATC_LVL_512: thr = (AW+1)'(atc_pkg::TH_L3_WORDS);
         default:              thr = (AW+1)'(atc_pkg::TH_SF_WORDS);
      endcase
      // Whole packet, or the threshold when not store-and-forward, whichever comes first
      start_ok = (occ_words != '0)
               && (pkt_ready || (!store_fwd && occ_words >= thr));
   end
endmodule

// ==== dv/atc_props.sv ====
/* Port checker for atc_ctl.
   Assumes one clock, RESET_N synchronous active low, bound to atc_ctl. */
module atc_props #(
   parameter int AW = 9
) (
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   input wire logic        GLOBAL_RESET_PIN_N,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        LINK_FEATURE_MASTER_GATE,
   input wire logic        RETRIES_ZERO,
   input wire logic        IN_VALID,
   input wire logic        IN_READY,
   input wire logic        IN_LAST,
   input wire logic        OUT_VALID,
   input wire logic        OUT_READY,
   input wire logic [31:0] OUT_DATA,
   input wire logic        OUT_LAST,
   input wire logic        OUT_ABORT,
   input wire logic        PIPELINE_EN
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] shadow;
   logic [7:0]  pkts;
   logic        mid;
   logic        retry;
   wire         in_eop = IN_VALID && IN_READY && IN_LAST;
   wire         acc    = OUT_VALID && OUT_READY;
   // Expected register image and whole packets held in the FIFO
   always_ff @(posedge CLK_SYS) begin
      if (!GLOBAL_RESET_PIN_N)
         shadow <= atc_pkg::LEC_RESET;
      else if (REG_WR && REG_ADDR == atc_pkg::LEC_OFFSET)
         shadow <= REG_WDATA & 32'h0000_B000;
      if (!RESET_N || !GLOBAL_RESET_PIN_N) begin
         pkts  <= 8'h00;
         mid   <= 1'b0;
         retry <= 1'b0;
      end else begin
         pkts  <= pkts + 8'(in_eop) - 8'(acc && OUT_LAST);
         mid   <= acc ? !OUT_LAST : mid && !OUT_ABORT;
         retry <= OUT_ABORT || (retry && !(acc && OUT_LAST));
      end
   end
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   sequence rd_lec;
      $past(REG_RD) && $past(REG_ADDR) == atc_pkg::LEC_OFFSET;
   endsequence
   sequence pkt_start;
      $rose(OUT_VALID) && !mid;
   endsequence
   a_rdata_idle_zero: assert property (!$past(REG_RD) |->
      REG_RDATA == 32'h0000_0000) else $error("stray read data");
   a_lec_readback: assert property (rd_lec |->
      REG_RDATA == shadow) else $error("enhancement register mismatch");
   a_pipe_gate: assert property (PIPELINE_EN ==
      !(LINK_FEATURE_MASTER_GATE && shadow[atc_pkg::REORDER_BIT]))
      else $error("pipeline enable wrong");
   a_abort_pulse: assert property (OUT_ABORT |=> !OUT_ABORT)
      else $error("abort longer than one cycle");
   a_out_hold: assert property (OUT_VALID && !OUT_READY |=>
      OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
      else $error("output word not held");
   a_last_idle: assert property (acc && OUT_LAST |=>
      !OUT_VALID [*2]) else $error("no idle after packet end");
   a_sf_retries: assert property (pkt_start |->
      !$past(RETRIES_ZERO, 2) || pkts != 8'h00)
      else $error("early start with zero retries");
   a_sf_gate: assert property (pkt_start |->
      $past(LINK_FEATURE_MASTER_GATE, 2) || pkts != 8'h00)
      else $error("early start with gate off");
   a_retry_whole: assert property (pkt_start |->
      !retry || pkts != 8'h00) else $error("retry sent before whole");
endmodule
bind atc_ctl atc_props #(.AW(AW)) atc_props_i (
   .CLK_SYS, .RESET_N, .GLOBAL_RESET_PIN_N, .REG_ADDR, .REG_WDATA,
   .REG_WR, .REG_RD, .REG_RDATA, .LINK_FEATURE_MASTER_GATE,
   .RETRIES_ZERO, .IN_VALID, .IN_READY, .IN_LAST, .OUT_VALID,
   .OUT_READY, .OUT_DATA, .OUT_LAST, .OUT_ABORT, .PIPELINE_EN);

// ==== dv/atc_phy_model.sv ====
/* Physical-layer sink for atc_ctl: paces OUT_READY, keeps words.
   Assumes the bench empties rxq before each packet. */
module atc_phy_model (
   input  wire logic        CLK_SYS,
   input  wire logic        slow,
   input  wire logic        OUT_VALID,
   output logic             OUT_READY,
   input  wire logic [31:0] OUT_DATA,
   input  wire logic        OUT_LAST,
   input  wire logic        OUT_ABORT
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] rxq[$];
   int          pkts = 0;
   logic [1:0]  cnt  = 2'b00;
   initial OUT_READY = 1'b1;
   always @(posedge CLK_SYS) begin
      cnt <= cnt + 2'b01;
      OUT_READY <= !slow || cnt == 2'b11;
      // Aborted frame is void at the receiver
      if (OUT_ABORT)
         rxq.delete();
      if (OUT_VALID && OUT_READY) begin
         rxq.push_back(OUT_DATA);
         if (OUT_LAST)
            pkts <= pkts + 1;
      end
   end
endmodule

// ==== dv/atc_ctl_tb.sv ====
/* Self-checking bench for atc_ctl with a physical-layer sink model.
   Assumes the hand-over timing and the package constants. */
module atc_ctl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK_SYS = 1'b0, RESET_N = 1'b0, GLOBAL_RESET_PIN_N = 1'b1;
   logic [7:0] REG_ADDR = 8'h00;
   logic [31:0] REG_WDATA = 32'h0000_0000, IN_DATA = 32'h0000_0000;
   logic REG_WR = 1'b0, REG_RD = 1'b0, LINK_FEATURE_MASTER_GATE = 1'b0;
   logic RETRIES_ZERO = 1'b0, IN_VALID = 1'b0, IN_LAST = 1'b0, slow = 1'b0;
   wire [31:0] REG_RDATA, OUT_DATA;
   wire IN_READY, OUT_VALID, OUT_READY, OUT_LAST, OUT_ABORT, PIPELINE_EN;
   int err_count = 0, checked = 0, cyc = 0, p0, n, m;
   logic [31:0] word = 32'h0000_0100, base;
   logic seen, took;
   logic [1:0] lv[6] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b11, 2'b11};
   logic gt[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic rz[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   int th[6] = '{atc_pkg::TH_L1_WORDS, atc_pkg::TH_L2_WORDS,
                 atc_pkg::TH_L3_WORDS, 0, 0, 0};
   atc_ctl #(.AW(9)) atc_ctl_i (.CLK_SYS, .RESET_N, .GLOBAL_RESET_PIN_N,
      .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
      .LINK_FEATURE_MASTER_GATE, .RETRIES_ZERO, .IN_VALID, .IN_READY,
      .IN_DATA, .IN_LAST, .OUT_VALID, .OUT_READY, .OUT_DATA, .OUT_LAST,
      .OUT_ABORT, .PIPELINE_EN);
   atc_phy_model phy_i (.CLK_SYS, .slow, .OUT_VALID, .OUT_READY,
      .OUT_DATA, .OUT_LAST, .OUT_ABORT);
   always #12.5 CLK_SYS = ~CLK_SYS;
   task automatic give_verdict();
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      @(negedge CLK_SYS);
      check(REG_RDATA, exp);
      @(posedge CLK_SYS);
   endtask
   task automatic gate(input logic g, input logic exp);
      LINK_FEATURE_MASTER_GATE <= g;
      @(negedge CLK_SYS);
      check(32'(PIPELINE_EN), 32'(exp));
      @(posedge CLK_SYS);
   endtask
   // Words go in one per cycle; a gap cycle follows each burst
   task automatic send(input int cnt, input logic last);
      for (int i = 0; i < cnt; i++) begin
         IN_VALID <= 1'b1;
         IN_DATA <= word;
         IN_LAST <= last && i == cnt - 1;
         do begin
            @(negedge CLK_SYS);
            took = IN_READY;
            @(posedge CLK_SYS);
         end while (took !== 1'b1);
         word++;
      end
      IN_VALID <= 1'b0;
      IN_LAST <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   // k: 0 start of output, 1 abort, 2 packet received whole
   task automatic wait_ev(input int cyc_n, input int k);
      seen = 1'b0;
      repeat (cyc_n) begin
         @(negedge CLK_SYS);
         seen |= k == 0 ? OUT_VALID : k == 1 ? OUT_ABORT : phy_i.pkts != p0;
      end
      @(posedge CLK_SYS);
   endtask
   task automatic new_pkt();
      base = word;
      p0 = phy_i.pkts;
      phy_i.rxq.delete();
   endtask
   initial begin
      repeat (5) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      GLOBAL_RESET_PIN_N <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      GLOBAL_RESET_PIN_N <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      rdc(atc_pkg::LEC_OFFSET, atc_pkg::LEC_RESET);
      rdc(8'h00, 32'h0000_0000);
      wr(atc_pkg::LEC_OFFSET, 32'hFFFF_BFFF);
      rdc(atc_pkg::LEC_OFFSET, 32'h0000_B000);
      gate(1'b1, 1'b0);
      gate(1'b0, 1'b1);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      rdc(atc_pkg::LEC_OFFSET, 32'h0000_B000);
      for (int k = 0; k < 6; k++) begin
         wr(atc_pkg::LEC_OFFSET, 32'(lv[k]) << atc_pkg::LEVEL_LSB);
         LINK_FEATURE_MASTER_GATE <= gt[k];
         RETRIES_ZERO <= rz[k];
         slow <= k == 1;
         n = th[k] != 0 ? th[k] - 1 : 200;
         m = th[k] != 0 ? th[k] + 20 : 201;
         new_pkt();
         send(n, 1'b0);
         wait_ev(8, 0);
         check(32'(seen), 32'h0000_0000);
         rdc(atc_pkg::STAT_OFFSET, 32'(n)
            | (32'(th[k] == 0) << atc_pkg::STAT_SF_BIT));
         if (th[k] != 0) begin
            send(1, 1'b0);
            wait_ev(4, 0);
            check(32'(seen), 32'h0000_0001);
            send(20, 1'b1);
         end else
            send(1, 1'b1);
         wait_ev(1500, 2);
         check(32'(phy_i.rxq.size()), 32'(m));
         check(phy_i.rxq[0], base);
      end
      RETRIES_ZERO <= 1'b0;
      new_pkt();
      send(130, 1'b0);
      wait_ev(400, 1);
      check(32'(seen), 32'h0000_0001);
      send(10, 1'b0);
      wait_ev(20, 0);
      check(32'(seen), 32'h0000_0000);
      rdc(atc_pkg::STAT_OFFSET, 32'h0000_008C
         | (32'h0000_0001 << atc_pkg::STAT_RETRY_BIT)
         | (32'h0000_0001 << atc_pkg::STAT_SF_BIT));
      send(1, 1'b1);
      wait_ev(1200, 2);
      check(32'(phy_i.rxq.size()), 32'd141);
      check(phy_i.rxq[0], base);
      GLOBAL_RESET_PIN_N <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      GLOBAL_RESET_PIN_N <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      rdc(atc_pkg::LEC_OFFSET, atc_pkg::LEC_RESET);
      wr(atc_pkg::LEC_OFFSET, atc_pkg::LEC_RESET);
      give_verdict();
   end
endmodule
